// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import uirda_pkg::*;

    logic           ref_clk;
    logic           nrst;
    logic [1:0]     en;
    logic [31:0]    div;
    logic [1:0]     utx;
    logic [1:0]     urdy;
    wire  [1:0]     rxin;
    logic [1:0]     txout;
    logic [1:0]     urx;
    int             n_errors = 0;
    int             checks_done = 0;
    logic           watch = 1'b0;
    int             wch = 0;
    int             p0 = 0;

    uart_infrared_endec i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .infrared_codec_enable(en),
        .baud_divisor_value(div), .uart_tx(utx), .uart_tx_ready(urdy),
        .modulated_rx_in(rxin), .modulated_tx_out(txout), .uart_rx(urx));
    uirda_xcvr_model i_x0 (.ref_clk(ref_clk), .led_in(txout[0]),
        .pulse_out(rxin[0]));
    uirda_xcvr_model i_x1 (.ref_clk(ref_clk), .led_in(txout[1]),
        .pulse_out(rxin[1]));

    // ------------------------------------------------------------
    // clock, report and compare helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    // idle channel must stay dark and the active channel's uart rx high meanwhile
    always @(negedge ref_clk) begin
        if (watch && (urx[wch] !== 1'b1 || txout[1 - wch] !== 1'b0))
            check(16'h0001, 16'h0000);
    end

    task automatic wait_rise(input int ch);
        int k;
        k = 0;
        while (txout[ch] !== 1'b1 && k < 2000) begin
            @(negedge ref_clk);
            k++;
        end
        if (txout[ch] !== 1'b1) begin
            n_errors++;
            complete_run();
        end
    endtask

    // width of the lit part, then cycles until the next rise
    task automatic meas(input int ch, input int lim, output int hi,
                        output int per);
        hi = 0;
        while (txout[ch] === 1'b1 && hi < lim) begin
            @(negedge ref_clk);
            hi++;
        end
        per = hi;
        while (txout[ch] !== 1'b1 && per < lim) begin
            @(negedge ref_clk);
            per++;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic scn_bypass();
        @(negedge ref_clk);
        utx[0] = 1'b0;
        @(negedge ref_clk);
        check(txout[0], 1'b0);
        utx[0] = 1'b1;
        i_x0.hold(1'b1);
        check(txout[0], 1'b1);
        repeat (2) @(negedge ref_clk);
        check(urx[0], 1'b0);
        @(negedge ref_clk);
        check(urx[0], 1'b1);
        i_x0.hold(1'b0);
        // let the dark level pass the sync before the codec takes the pin
        repeat (2) @(negedge ref_clk);
        en = 2'b11;
        repeat (40) @(negedge ref_clk);
        check(txout, 2'b00);
        check(urx, 2'b11);
        check(urdy, 2'b11);
    endtask

    task automatic scn_encode(input int ch, input int dv);
        int hi;
        int per;
        logic [5:0] bits;
        bits = 6'b110100;
        wch = ch;
        watch = 1'b1;
        fork
            for (int i = 0; i < 6; i++) begin
                utx[ch] = bits[i];
                if (i == 2 && ch == 0)
                    fork i_x0.send(8'h00, 1, dv); join_none
                repeat (16 * dv) @(negedge ref_clk);
            end
            begin
                wait_rise(ch);
                meas(ch, 48 * dv, hi, per);
                check(hi, 3 * dv);
                check(per, 16 * dv);
                meas(ch, 48 * dv, hi, per);
                check(hi, 3 * dv);
                check(per, 32 * dv);
                meas(ch, 48 * dv, hi, per);
                check(hi, 3 * dv);
                check(per, 48 * dv);
            end
        join
        watch = 1'b0;
    endtask

    task automatic scn_decode(input int dv);
        int lo;
        lo = 0;
        fork
            i_x0.send(8'h04, 3, dv);
            begin
                while (urx[0] !== 1'b0 && lo < 200) begin
                    @(negedge ref_clk);
                    lo++;
                end
                check(urx[0], 1'b0);
                lo = 0;
                while (urx[0] === 1'b0 && lo < 200) begin
                    @(negedge ref_clk);
                    lo++;
                end
                check(lo, 32 * dv);
                repeat (16 * dv) @(negedge ref_clk);
                check(urx[0], 1'b1);
            end
        join
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end

    // main sequence, uart assumed enabled throughout
    initial begin
        nrst = 1'b0;
        en = 2'b00;
        utx = 2'b11;
        div = {16'h0002, 16'h0001};
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        scn_bypass();
        p0 = i_x0.pulses_seen;
        scn_encode(0, 1);
        scn_encode(1, 2);
        scn_decode(1);
        check(16'(i_x0.pulses_seen - p0), 16'h0003);
        complete_run();
    end
endmodule // tb_top

`default_nettype wire

// *** bench/uirda_xcvr_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// infrared transceiver stand-in: pulses toward the rx pin
// ------------------------------------------------------------
module uirda_xcvr_model (
    input  wire logic   ref_clk,
    input  wire logic   led_in,
    output logic        pulse_out
);
    int pulses_seen = 0;

    // dark receiver idles low, so no stale level lingers
    initial pulse_out = 1'b0;

    // count light pulses coming from the encoder
    always @(posedge led_in) pulses_seen++;

    // steady level for bypass traffic
    task automatic hold(input logic lvl);
        @(negedge ref_clk);
        pulse_out = lvl;
    endtask

    // 16 ticks a bit, a 0 gives 7 dark, 3 lit, 6 dark ticks
    task automatic send(input logic [7:0] bits, input int n, input int dv);
        for (int i = 0; i < n; i++) begin
            repeat (7 * dv) @(negedge ref_clk);
            pulse_out = ~bits[i];
            repeat (3 * dv) @(negedge ref_clk);
            pulse_out = 1'b0;
            repeat (6 * dv) @(negedge ref_clk);
        end
    endtask
endmodule // uirda_xcvr_model

`default_nettype wire

// *** hw/uart_infrared_endec.sv ***
// Functional notes
// - two independent encoder/decoder channels exist, one per uart.
// - with the codec enabled the link is half-duplex, never sending and receiving at once.
// - every encoded or decoded bit spans exactly 16 baud ticks.
// - a 1 bit keeps the modulated output low for all 16 ticks.
// - a 0 bit gives 7 ticks low, a 3-tick high pulse, then 6 ticks low.
// - when enabled the modulated signal, not raw uart tx, drives tx pin.
// - when enabled the rx pin feeds the decoder and uart rx is internal.
// - the decoder delivers the recovered bit stream to the uart receiver.
// - the decoder times its output with the uart baud-rate clock.
// - bit timing comes from the baud generator, any divisor allowed.
// - bit rate is system clock over sixteen times the 16-bit divisor.
// - only the first received bit may jitter, later bits are 16 ticks.
// - the enable bit routes data through the codec when 1, bypass at 0.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// fifo: buffers raw uart tx bits ahead of the encoder
// ----------------------------------------------------------------
module uirda_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic [WIDTH-1:0]   in_data,
    input  wire logic               in_valid,
    output logic                    in_ready,
    output logic      [WIDTH-1:0]   out_data,
    output logic                    out_valid,
    input  wire logic               out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
    logic             push, pop;

    // pointers carry one extra bit so full and empty are distinct
    always_comb begin
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_next   = push ? wr_reg + 1'b1 : wr_reg;
        rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
        in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        out_data  = mem_reg[rd_reg[AW-1:0]];
    end

    // storage and pointers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule // uirda_fifo

// ----------------------------------------------------------------
// one channel: baud tick, encoder, decoder, pin steering
// ----------------------------------------------------------------
module uirda_channel
    import uirda_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic           infrared_codec_enable,
    input  wire logic [15:0]    baud_divisor_value,
    input  wire logic           uart_tx,
    output logic                uart_tx_ready,
    input  wire logic           rx_pin,
    output logic                tx_pin,
    output logic                uart_rx
);
    // ------------------------------------------------------------
    // baud tick: the divisor alone, no /16 prescale, gives one tick per 1/16 bit
    // ------------------------------------------------------------
    logic [15:0] div_reg, div_next;
    logic        tick;

    // a lowered divisor or the reset value reloads at once, no stale count
    always_comb begin
        tick     = (div_reg <= 16'h0001) || (div_reg > baud_divisor_value);
        div_next = tick ? baud_divisor_value : div_reg - 16'h0001;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= DIVISOR_RESET;
        end else begin
            div_reg <= div_next;
        end
    end
    // one tick = divisor clocks, 16 ticks a bit, so rate = f/(16*div)

    // ------------------------------------------------------------
    // tx buffer and input sync
    // ------------------------------------------------------------
    logic fifo_bit, fifo_valid, fifo_pop;
    logic rx_s1_reg, rx_s2_reg;

    uirda_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_data   (uart_tx),
        .in_valid  (infrared_codec_enable && tick),
        .in_ready  (uart_tx_ready),
        .out_data  (fifo_bit),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // two flops before the pin reaches any logic
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
        end else begin
            rx_s1_reg <= rx_pin;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // encoder and decoder state
    // ------------------------------------------------------------
    uirda_dir_t dir_reg, dir_next;
    logic [3:0] ph_reg, ph_next;
    logic       bit_reg, bit_next;
    logic       txo_reg, txo_next;
    logic       rxo_reg, rxo_next;
    logic       hit_reg, hit_next;
    logic       sampled;

    // tx samples the raw line every tick the fifo has room, so the fifo holds 16 per bit
    always_comb begin
        dir_next = dir_reg;
        ph_next  = ph_reg;
        bit_next = bit_reg;
        hit_next = hit_reg;
        fifo_pop = 1'b0;
        sampled  = 1'b0;
        if (!infrared_codec_enable) begin
            dir_next = UIRDA_IDLE;
            ph_next  = 4'h0;
        end else if (tick) begin
            case (dir_reg)
                UIRDA_IDLE: begin
                    if (rx_s2_reg) begin
                        dir_next = UIRDA_RX;  // pulse starts a rx bit
                        ph_next  = 4'h1;
                        hit_next = 1'b1;
                    end else if (fifo_valid && !fifo_bit) begin
                        dir_next = UIRDA_TX;  // start bit of a frame
                        fifo_pop = 1'b1;
                        bit_next = 1'b0;
                        ph_next  = 4'h1;
                    end else if (fifo_valid) begin
                        fifo_pop = 1'b1;      // idle marks drop out
                    end
                end
                UIRDA_TX: begin
                    fifo_pop = fifo_valid;
                    ph_next  = ph_reg + 4'h1;
                    if (ph_reg == 4'h0) begin // first sample of next bit
                        bit_next = fifo_valid ? fifo_bit : 1'b1;
                        if (fifo_valid && fifo_bit && bit_reg) begin
                            dir_next = UIRDA_IDLE;
                        end
                    end
                end
                UIRDA_RX: begin
                    ph_next = ph_reg + 4'h1;
                    if (rx_s2_reg) begin
                        hit_next = 1'b1;
                    end
                    if (ph_reg == LAST_TICK) begin
                        sampled  = 1'b1;
                        hit_next = rx_s2_reg; // a pulse on the edge wins
                        if (!hit_reg && !rx_s2_reg) begin
                            dir_next = UIRDA_IDLE; // no pulse: line idle
                        end
                    end
                end
                default: dir_next = UIRDA_IDLE;
            endcase
        end
    end

    // outputs: a pulse yields 0 for the bit, no pulse yields 1
    always_comb begin
        txo_next = 1'b0;
        if (infrared_codec_enable && dir_next == UIRDA_TX && !bit_next) begin
            txo_next = (ph_next >= PULSE_START) && (ph_next < PULSE_END);
        end // a 1 bit leaves txo low for all 16 ticks
        rxo_next = rxo_reg;
        if (dir_next == UIRDA_RX || dir_reg == UIRDA_RX) begin
            rxo_next = !(hit_next || hit_reg) ? 1'b1 : 1'b0;
        end
        if (sampled && !hit_reg && !rx_s2_reg) begin
            rxo_next = 1'b1;
        end
        if (!infrared_codec_enable || dir_next == UIRDA_IDLE) begin
            rxo_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dir_reg <= UIRDA_IDLE;
            ph_reg  <= 4'h0;
            bit_reg <= 1'b1;
            hit_reg <= 1'b0;
            txo_reg <= 1'b0;
            rxo_reg <= 1'b1;
        end else begin
            dir_reg <= dir_next;
            ph_reg  <= ph_next;
            bit_reg <= bit_next;
            hit_reg <= hit_next;
            txo_reg <= txo_next;
            rxo_reg <= rxo_next;
        end
    end

    // ------------------------------------------------------------
    // pin steering: bypass when the enable is clear
    // ------------------------------------------------------------
    logic tx_pin_next, uart_rx_next;
    always_comb begin
        tx_pin_next  = infrared_codec_enable ? txo_next : uart_tx;
        uart_rx_next = infrared_codec_enable ? rxo_next : rx_s2_reg;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_pin  <= 1'b1;
            uart_rx <= 1'b1;
        end else begin
            tx_pin  <= tx_pin_next;
            uart_rx <= uart_rx_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // lit time counted in ticks: slow divisors outrun any delay range
    logic [3:0] lit_ticks_reg, lit_ticks_next;
    always_comb begin
        lit_ticks_next = txo_reg ? lit_ticks_reg : 4'h0;
        if (txo_reg && tick && lit_ticks_reg != LAST_TICK) begin
            lit_ticks_next = lit_ticks_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lit_ticks_reg <= 4'h0;
        end else begin
            lit_ticks_reg <= lit_ticks_next;
        end
    end
    sequence s_pulse_fall;
        infrared_codec_enable && txo_reg ##1 !txo_reg;
    endsequence

    chk_pulse_width: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_pulse_fall |-> lit_ticks_reg == PULSE_END - PULSE_START)
        else $error("pulse not three ticks");
    chk_half_duplex: assert property (@(posedge ref_clk) disable iff (!nrst)
        dir_reg == UIRDA_TX |-> dir_next != UIRDA_RX)
        else $error("rx entered during tx");
    chk_bypass_tx: assert property (@(posedge ref_clk) disable iff (!nrst)
        !infrared_codec_enable |=> tx_pin == $past(uart_tx))
        else $error("bypass tx wrong");
    chk_bypass_rx: assert property (@(posedge ref_clk) disable iff (!nrst)
        !infrared_codec_enable |=> uart_rx == $past(rx_s2_reg))
        else $error("bypass rx wrong");
    chk_enc_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        infrared_codec_enable |=> tx_pin == $past(txo_next))
        else $error("tx pin not from encoder");
    chk_one_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        dir_reg == UIRDA_TX && bit_reg |-> !txo_reg)
        else $error("one bit pulsed");
    chk_phase_step: assert property (@(posedge ref_clk) disable iff (!nrst)
        tick && dir_reg == UIRDA_RX && infrared_codec_enable
        |=> ph_reg == $past(ph_reg) + 4'h1)
        else $error("phase skipped");
    chk_rx_idle_one: assert property (@(posedge ref_clk) disable iff (!nrst)
        dir_reg == UIRDA_IDLE && infrared_codec_enable |-> rxo_reg)
        else $error("idle rx not high");
endmodule // uirda_channel

// ----------------------------------------------------------------
// top: two channels, one per uart
// ----------------------------------------------------------------
module uart_infrared_endec
    import uirda_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic [1:0]     infrared_codec_enable,
    input  wire logic [31:0]    baud_divisor_value,
    input  wire logic [1:0]     uart_tx,
    output logic      [1:0]     uart_tx_ready,
    input  wire logic [1:0]     modulated_rx_in,
    output logic      [1:0]     modulated_tx_out,
    output logic      [1:0]     uart_rx
);
    // each channel has its own uart, divisor and enable
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        uirda_channel u_ch (
            .ref_clk               (ref_clk),
            .nrst                  (nrst),
            .infrared_codec_enable (infrared_codec_enable[i]),
            .baud_divisor_value    (baud_divisor_value[16*i +: 16]),
            .uart_tx               (uart_tx[i]),
            .uart_tx_ready         (uart_tx_ready[i]),
            .rx_pin                (modulated_rx_in[i]),
            .tx_pin                (modulated_tx_out[i]),
            .uart_rx               (uart_rx[i])
        );
    end
endmodule // uart_infrared_endec

`default_nettype wire

// *** hw/uirda_pkg.sv ***
package uirda_pkg;

    // ------------------------------------------------------------
    // bit timing, counted in baud-rate ticks (16 per bit)
    // ------------------------------------------------------------
    localparam int unsigned     TICKS_PER_BIT   = 16;
    localparam logic [3:0]      PULSE_START     = 4'h7;  // 7 ticks low
    localparam logic [3:0]      PULSE_END       = 4'ha;  // 3 ticks high
    localparam logic [3:0]      LAST_TICK       = 4'hf;
    localparam logic [15:0]     DIVISOR_RESET   = 16'hffff;
    localparam logic [3:0]      PRESCALE_LAST   = 4'hf;  // unused, a tick is divisor clocks

    // ------------------------------------------------------------
    // fifo and channel structure
    // ------------------------------------------------------------
    localparam int unsigned     CHANNELS        = 2;
    localparam int unsigned     FIFO_DEPTH      = 16;
    localparam int unsigned     FIFO_WIDTH      = 1;

    typedef enum logic [1:0] {
        UIRDA_IDLE = 2'b00,
        UIRDA_TX   = 2'b01,
        UIRDA_RX   = 2'b10
    } uirda_dir_t;

    // pin side of one channel
    typedef struct packed {
        logic tx_pin;
        logic rx_to_uart;
    } uirda_pins_t;

endpackage : uirda_pkg
